// *** rtl/pmo_ctrl.sv ***
// pmo_ctrl: soft mute ramp, beep routing, line output power states, level-control exit timing
// assumes inputs synchronous to clock; inValid is the one-cycle sample-rate tick
`timescale 1ns/1ps
module pmo_ctrl #(
  parameter int unsigned SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // playback sample stream
  input  wire logic                inValid,
  input  wire logic [SAMPLE_W-1:0] inSample,
  output logic                     outValid,
  output logic      [SAMPLE_W-1:0] outSample,
  // beep routing
  output logic                     beepPathOn,
  output logic                     beepToSpeaker,
  output logic                     beepToLine,
  output logic      [3:0]          beepSpkGainDb,
  // mono line output
  output logic                     converterToLine,
  output logic                     linePullDown,
  output logic                     linePowerSave,
  output logic                     lineEnabled,
  // level control
  output logic      [1:0]          levelCtrlRun,
  output logic      [1:0]          zeroCrossTimeout,
  output logic      [1:0]          recoveryWait
);

  typedef struct packed {
    logic [pmo_pkg::CTRL_W-1:0]  ctrl;
    logic [pmo_pkg::LEVEL_W-1:0] level;
    logic [7:0]                  gain;
    logic [SAMPLE_W-1:0]         sample;
    logic                        valid;
    logic [1:0]                  run;
    logic [10:0]                 tmRec;
    logic [10:0]                 tmPb;
    logic [31:0]                 rdata;
    pmo_pkg::pmo_line_t          line;
  } pmo_state_t;

  pmo_state_t st_r;
  pmo_state_t st_nxt;

  // timeout length for a two-bit code
  function automatic logic [10:0] timeoutLen(input logic [1:0] code);
    timeoutLen = pmo_pkg::TIMEOUT_BASE_FS << code;
  endfunction

  // one level-control channel: returns {run, count}
  function automatic logic [11:0] stepLevel(input logic en, input logic run, input logic [10:0] cnt,
                                            input logic [1:0] code, input logic tick);
    logic [10:0] inc;
    inc = cnt + 11'h001;
    if (en) begin
      stepLevel = {1'b1, 11'h000};
    end else if (run && tick) begin
      if (inc >= timeoutLen(code)) begin
        stepLevel = {1'b0, 11'h000};
      end else begin
        stepLevel = {1'b1, inc};
      end
    end else begin
      stepLevel = {run, cnt};
    end
  endfunction

  // sample times gain / span
  function automatic logic [SAMPLE_W-1:0] scaleSample(input logic [SAMPLE_W-1:0] s, input logic [7:0] g);
    logic signed [SAMPLE_W+26:0] prod;
    prod = $signed(s) * $signed({1'b0, g}) * $signed({1'b0, pmo_pkg::GAIN_RECIP});
    if (g == pmo_pkg::GAIN_MAX) begin
      scaleSample = s;
    end else begin
      scaleSample = prod[pmo_pkg::RECIP_SHIFT +: SAMPLE_W];
    end
  endfunction

  logic        access;
  logic        mapped;
  logic        softMute;
  logic [11:0] recStep;
  logic [11:0] pbStep;

  assign access   = psel && penable;
  assign mapped   = (paddr == pmo_pkg::ADDR_CTRL) || (paddr == pmo_pkg::ADDR_LEVEL) ||
                    (paddr == pmo_pkg::ADDR_STATUS);
  assign softMute = st_r.ctrl[pmo_pkg::C_SOFT_MUTE];
  assign recStep  = stepLevel(st_r.level[pmo_pkg::L_REC_EN], st_r.run[0], st_r.tmRec,
                              st_r.level[pmo_pkg::L_ZTM +: 2], inValid);
  assign pbStep   = stepLevel(st_r.level[pmo_pkg::L_PB_EN], st_r.run[1], st_r.tmPb,
                              st_r.level[pmo_pkg::L_ZTM +: 2], inValid);

  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    // zero wait state slave, read data captured in setup
    if (psel && !penable) begin
      case (paddr)
        pmo_pkg::ADDR_CTRL:   st_nxt.rdata = 32'(st_r.ctrl);
        pmo_pkg::ADDR_LEVEL:  st_nxt.rdata = 32'(st_r.level);
        pmo_pkg::ADDR_STATUS: st_nxt.rdata = 32'({st_r.line, st_r.run,
                                                  (st_r.gain != pmo_pkg::GAIN_MAX) && (st_r.gain != 8'h00),
                                                  st_r.gain});
        default:              st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite) begin
      case (paddr)
        pmo_pkg::ADDR_CTRL:  st_nxt.ctrl  = pwdata[pmo_pkg::CTRL_W-1:0];
        pmo_pkg::ADDR_LEVEL: st_nxt.level = pwdata[pmo_pkg::LEVEL_W-1:0];
        default:             st_nxt.ctrl  = st_r.ctrl;
      endcase
    end
    // soft mute on the sample stream, one step per sample
    if (inValid) begin
      st_nxt.sample = scaleSample(inSample, st_r.gain);
      st_nxt.valid  = 1'b1;
      if (softMute && st_r.gain != 8'h00) begin
        st_nxt.gain = st_r.gain - 8'h01;
      end else if (!softMute && st_r.gain != pmo_pkg::GAIN_MAX) begin
        st_nxt.gain = st_r.gain + 8'h01;
      end
    end
    // level control exits to manual only after the timeout
    st_nxt.run[0] = recStep[11];
    st_nxt.tmRec  = recStep[10:0];
    st_nxt.run[1] = pbStep[11];
    st_nxt.tmPb   = pbStep[10:0];
    // mono line output power state
    if (st_r.ctrl[pmo_pkg::C_LINE_SAVE]) begin
      st_nxt.line = pmo_pkg::LINE_SAVE;
    end else if (st_r.ctrl[pmo_pkg::C_LINE_PWR]) begin
      st_nxt.line = pmo_pkg::LINE_UP;
    end else begin
      st_nxt.line = pmo_pkg::LINE_DOWN;
    end
    if (sys_rst) begin
      st_nxt       = '0;
      st_nxt.ctrl  = pmo_pkg::CTRL_RST;
      st_nxt.level = pmo_pkg::LEVEL_RST;
      st_nxt.gain  = pmo_pkg::GAIN_MAX;
      st_nxt.line  = pmo_pkg::LINE_DOWN;
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // bus answers
  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // sample output
  assign outValid  = st_r.valid;
  assign outSample = st_r.sample;

  // beep routing and gain
  assign beepPathOn    = st_r.ctrl[pmo_pkg::C_BEEP_PWR];
  assign beepToSpeaker = st_r.ctrl[pmo_pkg::C_BEEP_SPK] && beepPathOn;
  assign beepToLine    = st_r.ctrl[pmo_pkg::C_BEEP_LINE] && beepPathOn;
  assign beepSpkGainDb = pmo_pkg::BEEP_GAIN_BASE +
                         4'(pmo_pkg::BEEP_GAIN_STEP * {2'b00, st_r.ctrl[pmo_pkg::C_SPK_GAIN +: 2]});

  // line output
  assign converterToLine = st_r.ctrl[pmo_pkg::C_CONV_LINE];
  assign linePullDown    = st_r.line == pmo_pkg::LINE_DOWN;
  assign linePowerSave   = st_r.line == pmo_pkg::LINE_SAVE;
  assign lineEnabled     = st_r.line == pmo_pkg::LINE_UP;

  // level control settings seen by the limiter; host keeps them stable while running
  assign levelCtrlRun     = st_r.run;
  assign zeroCrossTimeout = st_r.level[pmo_pkg::L_ZTM +: 2];
  assign recoveryWait     = st_r.level[pmo_pkg::L_WTM +: 2];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  AST_MUTE_STEP: assert property (inValid && softMute && st_r.gain != 8'h00 |=>
                                  st_r.gain == $past(st_r.gain) - 8'h01)
    else $error("mute ramp did not step down");

  AST_MUTE_ZERO: assert property (inValid && st_r.gain == 8'h00 |=> outValid && outSample == '0)
    else $error("muted sample not zero");

  AST_UNMUTE_STEP: assert property (inValid && !softMute && st_r.gain != pmo_pkg::GAIN_MAX |=>
                                    st_r.gain == $past(st_r.gain) + 8'h01)
    else $error("unmute ramp did not step up");

  AST_CANCEL_REVERSE: assert property (!softMute && st_r.gain != pmo_pkg::GAIN_MAX |=>
                                       st_r.gain >= $past(st_r.gain))
    else $error("cancelled mute kept attenuating");

  AST_PASS_THROUGH: assert property (inValid && st_r.gain == pmo_pkg::GAIN_MAX |=>
                                     outValid && outSample == $past(inSample))
    else $error("unity gain altered sample");

  AST_GAIN_STEADY: assert property (!inValid |=> $stable(st_r.gain) && st_r.gain <= pmo_pkg::GAIN_MAX)
    else $error("gain moved without a sample");

  AST_TIMEOUT_EXIT: assert property (st_r.run[1] && !st_r.level[pmo_pkg::L_PB_EN] && inValid &&
                                     st_r.tmPb == timeoutLen(zeroCrossTimeout) - 11'h001
                                     |=> !levelCtrlRun[1])
    else $error("manual mode not entered at timeout");

  AST_TIMEOUT_HOLD: assert property (st_r.run[0] && !st_r.level[pmo_pkg::L_REC_EN] &&
                                     st_r.tmRec < timeoutLen(zeroCrossTimeout) - 11'h001 |=> levelCtrlRun[0])
    else $error("manual mode entered early");

  AST_BEEP_ROUTE: assert property ((beepToSpeaker || beepToLine) |-> beepPathOn)
    else $error("beep routed while powered down");

  AST_BEEP_GAIN: assert property (beepSpkGainDb inside {4'h8, 4'ha, 4'hc, 4'he})
    else $error("beep speaker gain out of range");

  AST_LINE_SAVE: assert property (st_r.ctrl[pmo_pkg::C_LINE_SAVE] |=> linePowerSave && !lineEnabled)
    else $error("power-save not held");

  AST_LINE_STATES: assert property (!st_r.ctrl[pmo_pkg::C_LINE_SAVE] |=>
                                    lineEnabled == $past(st_r.ctrl[pmo_pkg::C_LINE_PWR]) &&
                                    linePullDown == !$past(st_r.ctrl[pmo_pkg::C_LINE_PWR]))
    else $error("line state mismatch");

  // ramp bounds and step size
  AST_MUTE_FLOOR: assert property (softMute && st_r.gain == 8'h00 |=> st_r.gain == 8'h00)
    else $error("muted gain left zero");

  AST_UNITY_CEIL: assert property (!softMute && st_r.gain == pmo_pkg::GAIN_MAX |=>
                                   st_r.gain == pmo_pkg::GAIN_MAX)
    else $error("unity gain left full scale");

  AST_UNITY_REACH: assert property (!softMute && inValid && st_r.gain == pmo_pkg::GAIN_MAX - 8'h01 |=>
                                    st_r.gain == pmo_pkg::GAIN_MAX)
    else $error("unmute ramp did not reach unity");

  AST_GAIN_RANGE: assert property (st_r.gain <= pmo_pkg::GAIN_MAX)
    else $error("gain above unity");

  AST_STEP_SIZE: assert property (inValid |=> $stable(st_r.gain) ||
                                  st_r.gain == $past(st_r.gain) + 8'h01 ||
                                  st_r.gain == $past(st_r.gain) - 8'h01)
    else $error("gain jumped by more than one step");

  // sample stream
  AST_SAMPLE_FLOW: assert property (outValid == $past(inValid))
    else $error("sample dropped or duplicated");

  AST_SAMPLE_HOLD: assert property (!inValid |=> $stable(outSample))
    else $error("output sample changed without input");

  // beep routing
  AST_BEEP_OFF: assert property (!st_r.ctrl[pmo_pkg::C_BEEP_PWR] |->
                                 !beepPathOn && !beepToSpeaker && !beepToLine)
    else $error("beep path live while powered down");

  AST_BEEP_ON: assert property (st_r.ctrl[pmo_pkg::C_BEEP_PWR] |-> beepPathOn)
    else $error("beep path not powered");

  AST_BEEP_SPK_SEL: assert property (beepPathOn && st_r.ctrl[pmo_pkg::C_BEEP_SPK] |->
                                     beepToSpeaker)
    else $error("beep not routed to speaker");

  AST_BEEP_LINE_SEL: assert property (beepPathOn && st_r.ctrl[pmo_pkg::C_BEEP_LINE] |->
                                      beepToLine)
    else $error("beep not routed to line");

  AST_BEEP_GAIN_CODE: assert property (beepSpkGainDb ==
                                       pmo_pkg::BEEP_GAIN_BASE + {1'b0, st_r.ctrl[pmo_pkg::C_SPK_GAIN +: 2], 1'b0})
    else $error("beep speaker gain does not follow code");

  // line output
  AST_CONV_LINE: assert property (converterToLine == st_r.ctrl[pmo_pkg::C_CONV_LINE])
    else $error("converter line output not following select");

  AST_LINE_ONEHOT: assert property ($onehot({linePullDown, linePowerSave, lineEnabled}))
    else $error("line output in more than one state");

  AST_LINE_DOWN: assert property (!st_r.ctrl[pmo_pkg::C_LINE_SAVE] && !st_r.ctrl[pmo_pkg::C_LINE_PWR] |=>
                                  linePullDown)
    else $error("line output not pulled down");

  AST_LINE_UP: assert property (!st_r.ctrl[pmo_pkg::C_LINE_SAVE] && st_r.ctrl[pmo_pkg::C_LINE_PWR] |=>
                                lineEnabled && !linePullDown)
    else $error("line output not powered");

  AST_SAVE_WITH_PWR: assert property (st_r.ctrl[pmo_pkg::C_LINE_SAVE] && st_r.ctrl[pmo_pkg::C_LINE_PWR] |=>
                                      linePowerSave)
    else $error("power-save lost with line power on");

  // level control
  AST_RUN_START_REC: assert property (st_r.level[pmo_pkg::L_REC_EN] |=> levelCtrlRun[0])
    else $error("record level control not running");

  AST_RUN_START_PB: assert property (st_r.level[pmo_pkg::L_PB_EN] |=> levelCtrlRun[1])
    else $error("playback level control not running");

  AST_TIMEOUT_EXIT_REC: assert property (st_r.run[0] && !st_r.level[pmo_pkg::L_REC_EN] && inValid &&
                                         st_r.tmRec == timeoutLen(zeroCrossTimeout) - 11'h001
                                         |=> !levelCtrlRun[0])
    else $error("record manual mode not entered at timeout");

  AST_TIMEOUT_HOLD_PB: assert property (st_r.run[1] && !st_r.level[pmo_pkg::L_PB_EN] &&
                                        st_r.tmPb < timeoutLen(zeroCrossTimeout) - 11'h001 |=> levelCtrlRun[1])
    else $error("playback manual mode entered early");

  AST_IDLE_STAYS_PB: assert property (!levelCtrlRun[1] && !st_r.level[pmo_pkg::L_PB_EN] |=>
                                      !levelCtrlRun[1])
    else $error("playback level control started unasked");

  AST_IDLE_STAYS_REC: assert property (!levelCtrlRun[0] && !st_r.level[pmo_pkg::L_REC_EN] |=>
                                       !levelCtrlRun[0])
    else $error("record level control started unasked");

  COV_FULL_MUTE: cover property (softMute && st_r.gain == 8'h01 && inValid ##1 st_r.gain == 8'h00);
  COV_CANCEL: cover property ($fell(softMute) && st_r.gain > 8'h10 && st_r.gain < 8'he0);
  COV_LINE_UP: cover property (linePowerSave ##[1:20] lineEnabled);
  COV_MANUAL: cover property ($fell(levelCtrlRun[1]));
  COV_REC_MANUAL: cover property ($fell(levelCtrlRun[0]));

endmodule

// *** rtl/pmo_pkg.sv ***
// pmo_pkg: constants for the playback mute and output control block
// assumes a 100 MHz clock and software access over APB
package pmo_pkg;
  // soft mute ramp length in sample periods
  localparam int unsigned MUTE_SPAN_FS    = 245;
  localparam logic [7:0]  GAIN_MAX        = 8'(MUTE_SPAN_FS);
  // gain reciprocal scaled by 2^24, rounded
  localparam int unsigned RECIP_SHIFT     = 24;
  localparam logic [16:0] GAIN_RECIP      = 17'(((1 << RECIP_SHIFT) + MUTE_SPAN_FS / 2) / MUTE_SPAN_FS);
  // zero-cross timeout base in sample periods
  localparam logic [10:0] TIMEOUT_BASE_FS = 11'h080;
  // beep to speaker gain in dB
  localparam logic [3:0]  BEEP_GAIN_BASE  = 4'h8;
  localparam logic [3:0]  BEEP_GAIN_STEP  = 4'h2;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_LEVEL      = 12'h004;
  localparam logic [11:0] ADDR_STATUS     = 12'h008;
  // control register fields
  localparam int unsigned CTRL_W          = 10;
  localparam logic [9:0]  CTRL_RST        = 10'h000;
  localparam int unsigned C_SOFT_MUTE     = 0;
  localparam int unsigned C_BEEP_PWR      = 1;
  localparam int unsigned C_BEEP_SPK      = 2;
  localparam int unsigned C_BEEP_LINE     = 3;
  localparam int unsigned C_PATH_MODE     = 4;
  localparam int unsigned C_SPK_GAIN      = 5;
  localparam int unsigned C_CONV_LINE     = 7;
  localparam int unsigned C_LINE_PWR      = 8;
  localparam int unsigned C_LINE_SAVE     = 9;
  // level control register fields
  localparam int unsigned LEVEL_W         = 8;
  localparam logic [7:0]  LEVEL_RST       = 8'h00;
  localparam int unsigned L_REC_EN        = 0;
  localparam int unsigned L_PB_EN         = 1;
  localparam int unsigned L_FILT_PWR      = 2;
  localparam int unsigned L_ZTM           = 4;
  localparam int unsigned L_WTM           = 6;
  // status register fields
  localparam int unsigned S_GAIN          = 0;
  localparam int unsigned S_RAMP_BUSY     = 8;
  localparam int unsigned S_RUN           = 9;
  localparam int unsigned S_LINE          = 11;
  // mono line output state
  typedef enum logic [1:0] {
    LINE_DOWN,
    LINE_SAVE,
    LINE_UP
  } pmo_line_t;
endpackage

// *** test/pmo_host.sv ***
// pmo_host: host controller model writing the control bits over apb
// assumes an apb slave on clock; transfers are started by the bench through tasks
`timescale 1ns/1ps
module pmo_host (
  // clock
  input  wire logic        clock,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int          timeouts;
  logic [31:0] rdData;
  logic        rdErr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timeouts = 0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) timeouts++;
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // path mode forced on whenever a beep bit is set
  task automatic wrCtrl(input logic [9:0] c);
    xfer(1'b1, pmo_pkg::ADDR_CTRL, {22'h0, c[9:5], c[4] | (|c[3:1]), c[3:0]});
  endtask
  // timers written with enables off, recovery wait equal to timeout
  task automatic wrLevel(input logic [1:0] en, input logic [1:0] ztm);
    xfer(1'b1, pmo_pkg::ADDR_LEVEL, {24'h0, ztm, ztm, 4'h0});
    // enables last; filter power bit stays at its reset value
    xfer(1'b1, pmo_pkg::ADDR_LEVEL, {24'h0, ztm, ztm, 2'b00, en});
  endtask
  // low-pop sequence: save, change power, settle, leave save
  task automatic lineSeq(input logic on, input int settle);
    wrCtrl(10'h200);
    wrCtrl({2'b11 & {1'b1, on}, 8'h00});
    repeat (settle) @(posedge clock);
    wrCtrl({1'b0, on, 8'h00});
  endtask
endmodule

// *** test/playback_mute_output_ctrl_test.sv ***
// playback_mute_output_ctrl_test: self-checking bench for pmo_ctrl
// assumes pmo_host as apb master; sample results checked from a queue of notes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module playback_mute_output_ctrl_test;
  logic clock, sys_rst, inValid;
  logic [15:0] inSample;
  wire logic psel, penable, pwrite, pready, pslverr, outValid;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [15:0] outSample;
  wire logic beepPathOn, beepToSpeaker, beepToLine, converterToLine;
  wire logic linePullDown, linePowerSave, lineEnabled;
  wire logic [3:0] beepSpkGainDb;
  wire logic [1:0] levelCtrlRun, zeroCrossTimeout, recoveryWait;
  int miscompares, nCompared, g, expQ[$], tolQ[$];
  logic [31:0] rnd;
  logic [9:0] c;
  logic signed [17:0] d;
  pmo_ctrl pmo_ctrl_i (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inValid(inValid),
    .inSample(inSample), .outValid(outValid), .outSample(outSample), .beepPathOn(beepPathOn),
    .beepToSpeaker(beepToSpeaker), .beepToLine(beepToLine), .beepSpkGainDb(beepSpkGainDb),
    .converterToLine(converterToLine), .linePullDown(linePullDown), .linePowerSave(linePowerSave),
    .lineEnabled(lineEnabled), .levelCtrlRun(levelCtrlRun), .zeroCrossTimeout(zeroCrossTimeout),
    .recoveryWait(recoveryWait));
  pmo_host pmo_host_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] nextRnd(input logic [31:0] x);
    nextRnd = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // samples with a noted expectation; gain steps toward the mute target
  task automatic sendSamples(input int n, input logic m);
    repeat (n) begin
      @(posedge clock);
      rnd = nextRnd(rnd);
      inValid <= 1'b1;
      inSample <= rnd[15:0];
      expQ.push_back(($signed(rnd[15:0]) * g) / 245);
      tolQ.push_back((g == 245 || g == 0) ? 0 : 1);
      g = m ? ((g > 0) ? g - 1 : 0) : ((g < 245) ? g + 1 : 245);
      @(posedge clock);
      inValid <= 1'b0;
    end
  endtask
  task automatic chkGain();
    pmo_host_i.xfer(1'b0, pmo_pkg::ADDR_STATUS, 32'h0);
    `CHK("gain", 8'(g), pmo_host_i.rdData[7:0])
    `CHK("rampBusy", (g > 0 && g < 245), pmo_host_i.rdData[8])
  endtask
  always @(posedge clock) if (outValid === 1'b1) begin
    if (expQ.size() == 0) `CHK("noteQueue", 1'b1, 1'b0)
    else begin
      d = 18'($signed(outSample)) - 18'(expQ[0]);
      `CHK("outSample", 1'b1, (tolQ[0] == 0) ? (outSample === 16'(expQ[0])) : (d <= 1 && d >= -1))
      void'(expQ.pop_front());
      void'(tolQ.pop_front());
    end
  end
  task automatic printVerdict();
    $display("compared %0d miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #900000;
    miscompares++;
    printVerdict();
  end
  initial begin
    int lens[4];
    sys_rst = 1'b1;
    inValid = 1'b0;
    inSample = 16'h0000;
    rnd = 32'ha9d3e4b3;
    miscompares = 0;
    nCompared = 0;
    g = 245;
    lens = '{100, 150, 250, 250};
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    pmo_host_i.xfer(1'b0, pmo_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrlReset", 32'h0, pmo_host_i.rdData)
    `CHK("pullDown", 1'b1, linePullDown)
    `CHK("spkGainReset", 4'h8, beepSpkGainDb)
    chkGain();
    for (int i = 0; i < 4; i++) begin
      pmo_host_i.wrCtrl({9'h0, ~i[0]});
      sendSamples(lens[i], ~i[0]);
      chkGain();
    end
    for (int i = 0; i < 16; i++) begin
      rnd = nextRnd(rnd);
      c = {i[3:2], rnd[7], i[1:0], rnd[4:1], 1'b0};
      pmo_host_i.wrCtrl(c);
      repeat (2) @(posedge clock);
      #1;
      `CHK("beepPath", c[1], beepPathOn)
      `CHK("beepSpk", c[2] & c[1], beepToSpeaker)
      `CHK("beepLine", c[3] & c[1], beepToLine)
      `CHK("spkGain", 4'(8 + 2 * c[6:5]), beepSpkGainDb)
      `CHK("convLine", c[7], converterToLine)
      `CHK("lineState", {~c[9] & ~c[8], c[9], c[8] & ~c[9]}, {linePullDown, linePowerSave, lineEnabled})
      pmo_host_i.xfer(1'b0, pmo_pkg::ADDR_CTRL, 32'h0);
      `CHK("ctrlBack", {22'h0, c[9:5], |c[4:1], c[3:0]}, pmo_host_i.rdData)
    end
    pmo_host_i.lineSeq(1'b1, 20);
    repeat (2) @(posedge clock);
    `CHK("lineUp", 1'b1, lineEnabled)
    pmo_host_i.lineSeq(1'b0, 20);
    repeat (2) @(posedge clock);
    `CHK("lineDown", 1'b1, linePullDown)
    for (int i = 0; i < 2; i++) begin
      pmo_host_i.wrLevel(2'(1 << i), 2'(i));
      repeat (2) @(posedge clock);
      `CHK("runOn", 2'(1 << i), levelCtrlRun)
      `CHK("timers", {2'(i), 2'(i)}, {zeroCrossTimeout, recoveryWait})
      pmo_host_i.wrLevel(2'b00, 2'(i));
      sendSamples((128 << i) - 4, 1'b0);
      `CHK("runHeld", 2'(1 << i), levelCtrlRun)
      sendSamples(6, 1'b0);
      `CHK("runOff", 2'b00, levelCtrlRun)
    end
    pmo_host_i.xfer(1'b1, pmo_pkg::ADDR_STATUS, 32'hffffffff);
    chkGain();
    pmo_host_i.xfer(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", 33'h100000000, {pmo_host_i.rdErr, pmo_host_i.rdData})
    repeat (4) @(posedge clock);
    `CHK("hostTimeouts", 0, pmo_host_i.timeouts)
    `CHK("notesLeft", 0, expQ.size())
    printVerdict();
  end
endmodule
